// ==== src/tc_conv_ctrl.sv ====
// Conversion sequencer, result and limit registers and APB slave of the temperature block
`timescale 1ns/1ns
`include "tc_defs.svh"

// Function
// - Once a run starts, both remote and local channels are converted automatically.
// - Both channels are always measured, even if one is unused.
// - Results go to two registers and are compared with four limit registers.
// - A run starts on a host start command or internally in auto-convert mode.
// - Status byte carries a busy flag while a conversion is in progress.
// - During conversion, result reads return the previous complete results.
// - Address select pins are sampled at power-up to form the slave address.
// - Standby pin low means standby, high means operate.
// - Results and limits keep their contents through standby.
// - Each channel integrates over a 60 ms window before its result is stored.
// - Results have 8-bit resolution.
// - Alert output is open-drain, only ever pulled low.
// - Serial data is only sampled; its open-drain output is never enabled; serial clock is a host-driven input.
// - A two-channel conversion takes 125 ms from the starting stop bit.
// - Standby during a conversion aborts it; no result register is updated.
module tc_conv_ctrl #(
  parameter int WIN_CYCLES       = `TC_WIN_MS * `TC_CLK_KHZ,
  parameter int TAIL_CYCLES      = (`TC_CONV_MS - 2 * `TC_WIN_MS) * `TC_CLK_KHZ,
  parameter int RATE_UNIT_CYCLES = `TC_RATE_UNIT_MS * `TC_CLK_KHZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        smb_clk,
  input  wire logic        smb_data_in,
  output logic             smb_data_out,
  output logic             smb_data_oe_n,
  output logic             alert_out,
  output logic             alert_oe_n,
  output logic             irq,
  input  wire logic        hw_standby_n_pin,
  input  wire logic        addr_select_pin_0,
  input  wire logic        addr_select_pin_1,
  output logic             adc_chan_sel,
  output logic             adc_enable,
  input  wire logic [7:0]  adc_data,
  output logic [6:0]       slave_addr
);

  if (WIN_CYCLES < 1 || TAIL_CYCLES < 1 || RATE_UNIT_CYCLES < 1 || RATE_UNIT_CYCLES > 16_000_000) begin : g_bad
    $error("tc_conv_ctrl: cycle counts out of range");
  end

  // ==========================================================================
  // Pin synchronisers
  tc_pkg::tc_pins_type pins_raw;
  tc_pkg::tc_pins_type pins;
  logic                data_d;
  logic                stop_seen;

  assign pins_raw = {hw_standby_n_pin, smb_clk, smb_data_in, addr_select_pin_1, addr_select_pin_0};

  tc_sync #(
    .W       (5),
    .RST_VAL (5'h0C)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    (pins_raw),
    .q       (pins)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) data_d <= 1'b1;
    else          data_d <= pins.smb_data;
  end
  assign stop_seen     = pins.smb_clk & pins.smb_data & ~data_d;
  assign smb_data_out  = 1'b0;
  assign smb_data_oe_n = 1'b1;

  // ==========================================================================
  // Registers
  tc_pkg::tc_state_type       state;
  tc_pkg::tc_state_type       next_state;
  logic [31:0]                cnt;
  logic [31:0]                next_cnt;
  logic [1:0][7:0]            res;
  logic [1:0][7:0]            shadow;
  tc_pkg::tc_limits_type [1:0] lim;
  logic [4:0]                 status;
  logic [4:0]                 mask;
  logic [7:0]                 rate;
  logic                       cfg_stop;
  logic                       cfg_sync;
  logic [1:0]                 cap_cnt;

  // ==========================================================================
  // APB decode
  logic        wr_en;
  logic        rd_setup;
  logic        mapped;
  logic [31:0] rd_mux;
  logic        oneshot_wr;
  logic        stop_wr_set;

  assign wr_en      = psel & penable & pwrite;
  assign rd_setup   = psel & ~penable & ~pwrite;
  assign mapped     = paddr[1:0] == 2'b00 && paddr <= `TC_OFF_ADDR;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~mapped;
  assign oneshot_wr = wr_en && paddr == `TC_OFF_ONESHOT;
  assign stop_wr_set = wr_en && paddr == `TC_OFF_CONFIG && pwdata[`TC_CFG_STOP] && !cfg_stop;

  logic busy;
  assign busy = state == tc_pkg::TC_REMOTE || state == tc_pkg::TC_LOCAL || state == tc_pkg::TC_TAIL;

  assign rd_mux = paddr == `TC_OFF_REMOTE  ? {24'h00_0000, res[0]} :
                  paddr == `TC_OFF_LOCAL   ? {24'h00_0000, res[1]} :
                  paddr == `TC_OFF_STATUS  ? {24'h00_0000, busy, 2'b00, status} :
                  paddr == `TC_OFF_CONFIG  ? {25'h000_0000, cfg_stop, 5'h00, cfg_sync} :
                  paddr == `TC_OFF_RATE    ? {24'h00_0000, rate} :
                  paddr == `TC_OFF_RHIGH   ? {24'h00_0000, lim[0].high} :
                  paddr == `TC_OFF_RLOW    ? {24'h00_0000, lim[0].low} :
                  paddr == `TC_OFF_LHIGH   ? {24'h00_0000, lim[1].high} :
                  paddr == `TC_OFF_LLOW    ? {24'h00_0000, lim[1].low} :
                  paddr == `TC_OFF_MASK    ? {27'h000_0000, mask} :
                  paddr == `TC_OFF_ADDR    ? {25'h000_0000, slave_addr} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)      prdata <= 32'h0000_0000;
    else if (rd_setup) prdata <= rd_mux;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_stop <= 1'b0;
      cfg_sync <= 1'b0;
      rate     <= `TC_RST_RATE;
      mask     <= `TC_RST_MASK;
    end else if (wr_en) begin
      if (paddr == `TC_OFF_CONFIG) cfg_stop <= pwdata[`TC_CFG_STOP];
      if (paddr == `TC_OFF_CONFIG) cfg_sync <= pwdata[`TC_CFG_SYNC];
      if (paddr == `TC_OFF_RATE)   rate     <= pwdata[7:0];
      if (paddr == `TC_OFF_MASK)   mask     <= pwdata[4:0];
    end
  end

  // ==========================================================================
  // Limit registers, kept through standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim <= {2{`TC_RST_HIGH, `TC_RST_LOW}};
    end else if (wr_en) begin
      if (paddr == `TC_OFF_RHIGH) lim[0].high <= pwdata[7:0];
      if (paddr == `TC_OFF_RLOW)  lim[0].low  <= pwdata[7:0];
      if (paddr == `TC_OFF_LHIGH) lim[1].high <= pwdata[7:0];
      if (paddr == `TC_OFF_LLOW)  lim[1].low  <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // Address straps, caught once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_cnt    <= 2'd0;
      slave_addr <= 7'h00;
    end else if (cap_cnt != 2'd3) begin
      cap_cnt <= cap_cnt + 2'd1;
      if (cap_cnt == 2'd2) slave_addr <= `TC_ADDR_BASE | {5'h00, pins.addr_sel};
    end
  end

  // ==========================================================================
  // Sequencer
  logic        running;
  logic        abort;
  logic        commit;
  logic [31:0] rate_cycles;
  logic [31:0] load_val;

  assign running     = pins.standby_n & ~cfg_stop;
  assign abort       = ~pins.standby_n | stop_wr_set;
  assign commit      = state == tc_pkg::TC_TAIL && cnt == 32'd0 && !abort;
  assign rate_cycles = 32'(({24'h00_0000, rate} + 32'd1) * 32'(RATE_UNIT_CYCLES));
  assign load_val    = next_state == tc_pkg::TC_TAIL ? 32'(TAIL_CYCLES - 1) :
                       next_state == tc_pkg::TC_GAP  ? rate_cycles - 32'd1 : 32'(WIN_CYCLES - 1);
  assign adc_enable   = state == tc_pkg::TC_REMOTE || state == tc_pkg::TC_LOCAL;
  assign adc_chan_sel = state == tc_pkg::TC_LOCAL;

  always_comb begin
    next_state = state;
    unique case (state)
      tc_pkg::TC_IDLE: begin
        if (pins.standby_n && oneshot_wr) next_state = cfg_sync ? tc_pkg::TC_ARM : tc_pkg::TC_REMOTE;
        else if (running)                 next_state = tc_pkg::TC_REMOTE;
      end
      tc_pkg::TC_ARM: begin
        if (!pins.standby_n) next_state = tc_pkg::TC_IDLE;
        else if (stop_seen)  next_state = tc_pkg::TC_REMOTE;
      end
      tc_pkg::TC_REMOTE: begin
        if (abort)              next_state = tc_pkg::TC_IDLE;
        else if (cnt == 32'd0)  next_state = tc_pkg::TC_LOCAL;
      end
      tc_pkg::TC_LOCAL: begin
        if (abort)              next_state = tc_pkg::TC_IDLE;
        else if (cnt == 32'd0)  next_state = tc_pkg::TC_TAIL;
      end
      tc_pkg::TC_TAIL: begin
        if (abort)              next_state = tc_pkg::TC_IDLE;
        else if (cnt == 32'd0)  next_state = running ? tc_pkg::TC_GAP : tc_pkg::TC_IDLE;
      end
      tc_pkg::TC_GAP: begin
        if (!running)                       next_state = tc_pkg::TC_IDLE;
        else if (cnt == 32'd0 || oneshot_wr) next_state = tc_pkg::TC_REMOTE;
      end
      default: next_state = tc_pkg::TC_IDLE;
    endcase
  end

  assign next_cnt = next_state != state ? load_val : (cnt == 32'd0 ? cnt : cnt - 32'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= tc_pkg::TC_IDLE;
      cnt   <= 32'd0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // ==========================================================================
  // Shadow capture, commit and limit compare per channel
  logic [1:0] hi_hit;
  logic [1:0] lo_hit;
  logic [1:0] win_end;

  assign win_end[0] = state == tc_pkg::TC_REMOTE && cnt == 32'd0 && !abort;
  assign win_end[1] = state == tc_pkg::TC_LOCAL && cnt == 32'd0 && !abort;

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    assign hi_hit[ch] = $signed(shadow[ch]) > $signed(lim[ch].high);
    assign lo_hit[ch] = $signed(shadow[ch]) < $signed(lim[ch].low);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)         shadow[ch] <= 8'h00;
      else if (win_end[ch]) shadow[ch] <= adc_data;
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)    res[ch] <= 8'h00;
      else if (commit) res[ch] <= shadow[ch];
    end
  end

  // ==========================================================================
  // Sticky status, mask and alert
  logic [4:0] st_set;
  logic [4:0] st_clr;

  assign st_set = {5{commit}} & {lo_hit[1], hi_hit[1], lo_hit[0], hi_hit[0], 1'b1};
  assign st_clr = wr_en && paddr == `TC_OFF_STATUS ? pwdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status <= 5'h00;
    else          status <= (status & ~st_clr) | st_set;
  end

  assign irq        = |(status & mask);
  assign alert_out  = 1'b0;
  assign alert_oe_n = ~|status[4:`TC_ST_ALARM_LSB];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [31:0] busy_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)  busy_len <= 32'd0;
    else if (busy) busy_len <= busy_len + 32'd1;
    else           busy_len <= 32'd0;
  end

  sequence s_remote_done;
    state == tc_pkg::TC_REMOTE && cnt == 32'd0 && !abort;
  endsequence

  sequence s_local_begins;
    state == tc_pkg::TC_LOCAL;
  endsequence

  a_remote_then_local: assert property (s_remote_done |=> s_local_begins)
    else $error("local window did not follow remote window");
  a_both_captured: assert property (commit |-> busy_len == 32'(WIN_CYCLES * 2 + TAIL_CYCLES - 1))
    else $error("commit without both channel windows");
  a_commit_copies: assert property (commit |=> res[0] == $past(shadow[0]) && res[1] == $past(shadow[1]))
    else $error("results not taken from converter");
  a_oneshot_starts: assert property (state == tc_pkg::TC_IDLE && oneshot_wr && pins.standby_n && !cfg_sync
                                     |=> state == tc_pkg::TC_REMOTE)
    else $error("one-shot did not start a conversion");
  a_busy_read: assert property (rd_setup && paddr == `TC_OFF_STATUS && busy |=> prdata[`TC_ST_BUSY])
    else $error("busy not shown in status");
  a_results_held: assert property (busy && !commit |=> $stable(res))
    else $error("result changed mid conversion");
  a_addr_fixed: assert property (cap_cnt == 2'd3 |=> $stable(slave_addr))
    else $error("slave address changed after capture");
  a_standby_stops: assert property (!pins.standby_n |=> !busy)
    else $error("conversion ran in hardware standby");
  a_window_len: assert property ($rose(state == tc_pkg::TC_LOCAL) |-> busy_len == 32'(WIN_CYCLES))
    else $error("remote window length wrong");
  a_alert_drive: assert property (alert_out == 1'b0 && (status[4:1] == 4'h0 || !alert_oe_n))
    else $error("alert driven high or not pulled low");
  a_abort_keeps: assert property (busy && abort |=> state == tc_pkg::TC_IDLE && $stable(res))
    else $error("aborted conversion touched results");
  a_alarm_flag: assert property (commit && hi_hit[0] |=> status[1] && !alert_oe_n)
    else $error("remote high alarm not flagged");

endmodule // tc_conv_ctrl

// ==== src/tc_defs.svh ====
// Offsets, field positions, reset values and timing figures of the temperature conversion block
`ifndef TC_DEFS_SVH
`define TC_DEFS_SVH

// ==========================================================================
// Timing
`define TC_CLK_KHZ         10000
`define TC_WIN_MS          60
`define TC_CONV_MS         125
`define TC_RATE_UNIT_MS    125

// ==========================================================================
// Register byte offsets
`define TC_OFF_REMOTE      8'h00
`define TC_OFF_LOCAL       8'h04
`define TC_OFF_STATUS      8'h08
`define TC_OFF_CONFIG      8'h0C
`define TC_OFF_RATE        8'h10
`define TC_OFF_ONESHOT     8'h14
`define TC_OFF_RHIGH       8'h18
`define TC_OFF_RLOW        8'h1C
`define TC_OFF_LHIGH       8'h20
`define TC_OFF_LLOW        8'h24
`define TC_OFF_MASK        8'h28
`define TC_OFF_ADDR        8'h2C

// ==========================================================================
// Field positions
`define TC_ST_DONE         0
`define TC_ST_ALARM_LSB    1
`define TC_ST_BUSY         7
`define TC_CFG_SYNC        0
`define TC_CFG_STOP        6

// ==========================================================================
// Reset values
`define TC_RST_HIGH        8'h7F
`define TC_RST_LOW         8'h80
`define TC_RST_RATE        8'h02
`define TC_RST_MASK        5'h00
`define TC_ADDR_BASE       7'h18

`endif

// ==== src/tc_pkg.sv ====
// Types shared by the temperature conversion block
package tc_pkg;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    TC_IDLE   = 3'b000,
    TC_ARM    = 3'b001,
    TC_REMOTE = 3'b010,
    TC_LOCAL  = 3'b011,
    TC_TAIL   = 3'b100,
    TC_GAP    = 3'b101
  } tc_state_type;

  // ==========================================================================
  // Alarm limits of one channel
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } tc_limits_type;

  // ==========================================================================
  // Synchronised pin levels
  typedef struct packed {
    logic       standby_n;
    logic       smb_clk;
    logic       smb_data;
    logic [1:0] addr_sel;
  } tc_pins_type;

endpackage

// ==== src/tc_sync.sv ====
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module tc_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [W-1:0]  d_in,
  output logic [W-1:0]       q
);

  logic [W-1:0] meta;

  // ==========================================================================
  // Second stage alone reads the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d_in;
      q    <= meta;
    end
  end

endmodule // tc_sync

// ==== sim/tc_smb_host.sv ====
// Host side model of the serial link: start and stop framing
`timescale 1ns/1ns
module tc_smb_host (
  output logic smb_clk,
  output logic sda_pull
);
  localparam int HALF = 400;
  // ==========================================================================
  // Idle: clock high and still, data released to the pull-up
  initial begin
    smb_clk  = 1'b1;
    sda_pull = 1'b0;
  end
  // ==========================================================================
  // Start, one clock pulse, then stop
  task automatic frame();
    sda_pull = 1'b1;
    #HALF smb_clk = 1'b0;
    #HALF smb_clk = 1'b1;
    #HALF sda_pull = 1'b0;
    #HALF;
  endtask
endmodule // tc_smb_host

// ==== sim/dual_channel_temp_conversion_control_tb.sv ====
// Self-checking bench of the temperature conversion block
`timescale 1ns/1ns
`include "tc_defs.svh"
module dual_channel_temp_conversion_control_tb;
  localparam int WIN  = 20;
  localparam int TAIL = 5;
  localparam int UNIT = 10;
  logic        pclk, presetn, psel, penable, pwrite, standby_n, a0, a1, err, have_prev;
  logic [7:0]  paddr, adc_data, rem_v, loc_v, rd, prev_r, prev_l, r, l;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, smb_data_out, smb_data_oe_n, alert_out, alert_oe_n;
  logic        irq, adc_chan_sel, adc_enable, smb_clk, sda_pull;
  logic [6:0]  slave_addr;
  logic [7:0]  lim [4];
  logic [4:0]  mask, st;
  wire         sda_line;
  int          seed, fails, n_compared, cycles, en_cnt, loc_cnt;

  assign sda_line = sda_pull ? 1'b0 : (smb_data_oe_n ? 1'b1 : smb_data_out);

  tc_conv_ctrl #(.WIN_CYCLES(WIN), .TAIL_CYCLES(TAIL), .RATE_UNIT_CYCLES(UNIT)) tc_conv_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smb_clk(smb_clk), .smb_data_in(sda_line), .smb_data_out(smb_data_out),
    .smb_data_oe_n(smb_data_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n), .irq(irq),
    .hw_standby_n_pin(standby_n), .addr_select_pin_0(a0), .addr_select_pin_1(a1),
    .adc_chan_sel(adc_chan_sel), .adc_enable(adc_enable), .adc_data(adc_data), .slave_addr(slave_addr));
  tc_smb_host tc_smb_host_inst (.smb_clk(smb_clk), .sda_pull(sda_pull));

  // ==========================================================================
  // Clock, converter stand-in, window counters and timeout
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    adc_data <= adc_chan_sel ? loc_v : rem_v;
    cycles <= cycles + 1;
    if (adc_enable === 1'b1) en_cnt <= en_cnt + 1;
    if (adc_chan_sel === 1'b1) loc_cnt <= loc_cnt + 1;
    if (cycles == 10000) begin
      fails = fails + 1;
      complete_run();
    end
  end

  // ==========================================================================
  // Compare, bus and closing tasks
  task automatic check8(string n, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic check1(string n, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %b seen %b", n, e, g);
      fails++;
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(string n, logic [7:0] a, logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check8(n, e, rd);
  endtask
  task automatic wait_idle();
    do begin
      apb(1'b0, `TC_OFF_STATUS, 32'h0000_0000);
    end while (rd[7] !== 1'b0);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Expected status: done plus strict signed limit compares
  function automatic logic [4:0] exp_st(logic [7:0] rv, logic [7:0] lv);
    exp_st = {$signed(lv) < $signed(lim[3]), $signed(lv) > $signed(lim[2]),
              $signed(rv) < $signed(lim[1]), $signed(rv) > $signed(lim[0]), 1'b1};
  endfunction

  // ==========================================================================
  // One conversion: 0 one-shot, 1 one-shot after a stop condition, 2 auto
  task automatic run_conv(int mode);
    int e0, c0;
    rem_v <= r;
    loc_v <= l;
    e0 = en_cnt;
    c0 = loc_cnt;
    if (mode == 2) apb(1'b1, `TC_OFF_CONFIG, 32'h0000_0000);
    if (mode == 1) apb(1'b1, `TC_OFF_CONFIG, 32'h0000_0041);
    if (mode < 2) apb(1'b1, `TC_OFF_ONESHOT, 32'h0000_0000);
    if (mode == 1) begin
      repeat (20) @(posedge pclk);
      apb(1'b0, `TC_OFF_STATUS, 32'h0000_0000);
      check1("busy before stop", 1'b0, rd[7]);
      tc_smb_host_inst.frame();
    end
    apb(1'b0, `TC_OFF_STATUS, 32'h0000_0000);
    check1("busy", 1'b1, rd[7]);
    if (have_prev) rd_chk("remote old", `TC_OFF_REMOTE, prev_r);
    wait_idle();
    apb(1'b1, `TC_OFF_CONFIG, 32'h0000_0040);
    rd_chk("remote", `TC_OFF_REMOTE, r);
    rd_chk("local", `TC_OFF_LOCAL, l);
    check8("windows", 8'(2 * WIN), 8'(en_cnt - e0));
    check8("local window", 8'(WIN), 8'(loc_cnt - c0));
    st = exp_st(r, l);
    rd_chk("status", `TC_OFF_STATUS, {3'b000, st});
    check1("alert", ~|st[4:1], alert_oe_n);
    check1("irq", |(st & mask), irq);
    apb(1'b1, `TC_OFF_STATUS, 32'h0000_001F);
    rd_chk("status clear", `TC_OFF_STATUS, 8'h00);
    check1("alert clear", 1'b1, alert_oe_n);
    prev_r = r;
    prev_l = l;
    have_prev = 1'b1;
    $display("test conversion mode %0d done", mode);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 59041;
    {psel, penable, pwrite, standby_n, presetn, have_prev} = 6'b00_0000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    a0 = 1'($random(seed));
    a1 = 1'($random(seed));
    {rem_v, loc_v, adc_data} = 24'h00_0000;
    {fails, n_compared, cycles, en_cnt, loc_cnt} = '0;
    mask = 5'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    check8("slave addr", {1'b0, `TC_ADDR_BASE | {a1, a0}}, {1'b0, slave_addr});
    rd_chk("addr reg", `TC_OFF_ADDR, {1'b0, `TC_ADDR_BASE | {a1, a0}});
    rd_chk("rate", `TC_OFF_RATE, `TC_RST_RATE);
    for (int j = 0; j < 4; j++) begin
      lim[j] = j[0] ? `TC_RST_LOW : `TC_RST_HIGH;
      rd_chk("limit reset", 8'(8'h18 + 4 * j), lim[j]);
    end
    rd_chk("mask", `TC_OFF_MASK, 8'h00);
    apb(1'b0, 8'h30, 32'h0000_0000);
    check1("unmapped err", 1'b1, err);
    check1("data released", 1'b1, smb_data_oe_n);
    check1("data low level", 1'b0, smb_data_out);
    check1("alert never high", 1'b0, alert_out);
    $display("test reset done");
    apb(1'b1, `TC_OFF_CONFIG, 32'h0000_0040);
    standby_n <= 1'b1;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      if (i > 0) begin
        for (int j = 0; j < 4; j++) begin
          lim[j] = 8'($random(seed));
          apb(1'b1, 8'(8'h18 + 4 * j), {24'h00_0000, lim[j]});
        end
        mask = 5'($random(seed));
        apb(1'b1, `TC_OFF_MASK, {27'h000_0000, mask});
      end
      r = (i == 0) ? 8'h7F : 8'($random(seed));
      l = (i == 0) ? 8'h80 : 8'($random(seed));
      run_conv(0);
    end
    r = 8'($random(seed));
    l = 8'($random(seed));
    run_conv(1);
    r = 8'($random(seed));
    l = 8'($random(seed));
    run_conv(2);
    rem_v <= ~prev_r;
    loc_v <= ~prev_l;
    apb(1'b1, `TC_OFF_ONESHOT, 32'h0000_0000);
    repeat (10) @(posedge pclk);
    standby_n <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, `TC_OFF_STATUS, 32'h0000_0000);
    check1("busy abort", 1'b0, rd[7]);
    rd_chk("remote kept", `TC_OFF_REMOTE, prev_r);
    rd_chk("local kept", `TC_OFF_LOCAL, prev_l);
    for (int j = 0; j < 4; j++) rd_chk("limit kept", 8'(8'h18 + 4 * j), lim[j]);
    apb(1'b1, `TC_OFF_ONESHOT, 32'h0000_0000);
    repeat (5) @(posedge pclk);
    apb(1'b0, `TC_OFF_STATUS, 32'h0000_0000);
    check1("busy in standby", 1'b0, rd[7]);
    $display("test standby done");
    complete_run();
  end
endmodule // dual_channel_temp_conversion_control_tb
